/* File: adc_scan_sequencer.sv */
// scan sequencer and result store with apb register access
`timescale 1ns/100ps
`default_nettype none
// How it works
// (RULE1) single scan converts each selected channel once per trigger, then stops
// (RULE2) continuous scan reloads the selection after each pass until stopped
// (RULE3) single scan may add the temperature sensor as an extended input
// (RULE4) single scan may add the internal reference as an extended input
// (RULE5) group scan converts every channel of the triggered group once
// (RULE6) groups a and b have independent trigger source selects
// (RULE7) with priority, a group a trigger aborts group b and starts a
// (RULE8) with rescan, aborted group b restarts from its start after a
// (RULE9) timer pulse unit or event link unit trigger starts conversion
// (RULE10) software start and external pin start are accepted too
// (RULE11) 24 channel results plus duplicate, temperature, reference and diagnostic
// (RULE12) normal results are stored as 12-bit values
// (RULE13) addition mode stores a sum two or four bits wider
// (RULE14) double trigger works in single or group mode on one channel
// (RULE15) first double result to channel register, second to duplicate
// (RULE16) conversion clock ratio 1:1, 1:2, 2:1, 4:1 or 8:1
// (RULE17) each conversion slot is 1.4 us of a 32 MHz conversion clock
// (RULE18) scan end request pulses when a single scan completes
// (RULE19) in double trigger mode the request waits for both scans
// (RULE20) group a end pulses the main request, group b its own
// (RULE21) software picks per channel add or average; the code picks add per channel, average by one ctrl_q.avg bit for all
// (RULE22) channels convert in ascending order, unselected skipped at no cost
// (RULE23) a trigger for a group already scanning is ignored
module adc_scan_sequencer (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [adc_scan_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // start triggers
    input wire logic timer_pulse_unit_trig,
    input wire logic event_link_unit_trig,
    input wire logic external_start_pin_n,
    // converter core
    output adc_scan_pkg::conv_req_t conv_req,
    input wire logic [adc_scan_pkg::DATA_W-1:0] conv_data,
    // scan end requests
    output logic scan_end_irq,
    output logic group_b_scan_end_irq
);
    import adc_scan_pkg::*;
    default clocking chk_clk @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    typedef enum logic [1:0] {ST_IDLE, ST_PICK, ST_CONV} seq_state_t;

    ctrl_t ctrl_q;
    logic [NCH_ANA-1:0] sel_a_q, sel_b_q, addsel_q;
    logic [RES_W-1:0] res_q [NRES];
    seq_state_t st_q;
    logic grp_b_q, b_pend_q, dbl_ph_q;
    logic [NSLOT-1:0] rem_q;
    logic [SLOT_W-1:0] slot_q;
    logic [REP_W-1:0] rep_q;
    logic [RES_W-1:0] acc_q;
    logic pin_s1_q, pin_s2_q, pin_s3_q;
    conv_req_t conv_req_q;
    logic irq_a_q, irq_b_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;

    function automatic logic [CH_W-1:0] first_set(input logic [NSLOT-1:0] m);
        logic [CH_W-1:0] r;
        r = '0;
        for (int i = NSLOT - 1; i >= 0; i--) begin
            if (m[i]) begin
                r = CH_W'(i);
            end
        end
        return r;
    endfunction

    function automatic logic trig_sel(input logic [2:0] src, input logic tmr,
                                      input logic elk, input logic pin);
        return (src == TRG_TIMER) ? tmr : (src == TRG_ELINK) ? elk :
               (src == TRG_PIN) ? pin : 1'b0;
    endfunction

    function automatic logic [SLOT_W-1:0] slot_len(input logic [2:0] ratio);
        case (ratio)
            RATIO_1_2: return SLOT_1_2;
            RATIO_2_1: return SLOT_2_1;
            RATIO_4_1: return SLOT_4_1;
            RATIO_8_1: return SLOT_8_1;
            default: return SLOT_1_1;
        endcase
    endfunction

    // apb decode
    wire setup_w = psel && !penable;
    wire acc_w = psel && penable && pready_q;
    wire wr_w = acc_w && pwrite && !pslverr_q;
    wire wr_ctrl = wr_w && paddr == OFF_CTRL;
    ctrl_t wctrl;
    assign wctrl = ctrl_t'(pwdata[CTRL_W-1:0]);
    wire sw_start = wr_ctrl && wctrl.start;
    wire sw_stop = wr_ctrl && wctrl.stop;
    wire [ADDR_W-1:0] res_off = paddr - OFF_RES;
    wire [ADDR_W-1:0] res_word = res_off >> WORD_SHIFT;
    wire [CH_W-1:0] res_idx = CH_W'(res_word);
    wire is_res = paddr >= OFF_RES && res_word < ADDR_W'(NRES) && paddr[1:0] == 2'h0;
    wire is_reg = paddr == OFF_CTRL || paddr == OFF_SEL_A || paddr == OFF_SEL_B ||
                  paddr == OFF_ADDSEL || paddr == OFF_STATUS;
    status_t stat_w;
    assign stat_w = '{dbl_ph: dbl_ph_q, b_pend: b_pend_q, grp_b: grp_b_q,
                      busy: st_q != ST_IDLE, chan: conv_req_q.chan};
    wire [31:0] rd_w = (paddr == OFF_CTRL) ? 32'(ctrl_q) :
                       (paddr == OFF_SEL_A) ? 32'(sel_a_q) :
                       (paddr == OFF_SEL_B) ? 32'(sel_b_q) :
                       (paddr == OFF_ADDSEL) ? 32'(addsel_q) :
                       (paddr == OFF_STATUS) ? 32'(stat_w) :
                       is_res ? 32'(res_q[res_idx]) : 32'h0000_0000;

    // apb answer one cycle after setup, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup_w;
            pslverr_q <= setup_w && !(is_reg || is_res);
            prdata_q <= setup_w ? rd_w : 32'h0000_0000;
        end
    end

    // start and stop are strobes and never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= '0;
            sel_a_q <= '0;
            sel_b_q <= '0;
            addsel_q <= '0;
        end else if (wr_w) begin
            if (paddr == OFF_CTRL) begin
                ctrl_q <= ctrl_t'({wctrl[CTRL_W-1:2], 2'h0});
            end
            if (paddr == OFF_SEL_A) begin
                sel_a_q <= pwdata[NCH_ANA-1:0];
            end
            if (paddr == OFF_SEL_B) begin
                sel_b_q <= pwdata[NCH_ANA-1:0];
            end
            if (paddr == OFF_ADDSEL) begin
                addsel_q <= pwdata[NCH_ANA-1:0];
            end
        end
    end

    // external pin is asynchronous, active low start on falling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
            pin_s3_q <= 1'b1;
        end else begin
            pin_s1_q <= external_start_pin_n;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end
    wire pin_edge = pin_s3_q && !pin_s2_q; // [RULE10]

    // trigger and selection decode
    wire grp_mode = ctrl_q.mode == MODE_GROUP;
    wire single_mode = ctrl_q.mode == MODE_SINGLE || ctrl_q.mode == MODE_RSVD;
    wire dbl_on = ctrl_q.dbl_en && !(ctrl_q.mode == MODE_CONT); // [RULE14]
    wire trig_a = sw_start ||
        trig_sel(ctrl_q.trig_a, timer_pulse_unit_trig, event_link_unit_trig, pin_edge); // [RULE9] [RULE10]
    wire trig_b = grp_mode &&
        trig_sel(ctrl_q.trig_b, timer_pulse_unit_trig, event_link_unit_trig, pin_edge); // [RULE6]
    wire [2:0] ext_w = single_mode ? {ctrl_q.diag_en, ctrl_q.vref_en, ctrl_q.temp_en} : 3'h0; // [RULE3] [RULE4]
    wire [NSLOT-1:0] dbl_mask = NSLOT'(1) << ctrl_q.dbl_chan;
    wire [NSLOT-1:0] mask_a = dbl_on ? dbl_mask : {ext_w, sel_a_q}; // [RULE1] [RULE5] [RULE14]
    wire [NSLOT-1:0] mask_b = {3'h0, sel_b_q}; // [RULE5]
    wire preempt = st_q != ST_IDLE && grp_b_q && grp_mode && ctrl_q.prio && trig_a; // [RULE7]
    wire fin = st_q == ST_PICK && rem_q == '0;
    wire fin_a = fin && !grp_b_q && ctrl_q.mode != MODE_CONT;
    wire fin_a_wait = fin_a && dbl_on && !dbl_ph_q;

    // accumulation and result selection
    wire cur_ana = conv_req_q.chan < CH_W'(NCH_ANA);
    wire add_on = cur_ana && addsel_q[conv_req_q.chan];
    wire [REP_W-1:0] rep_last = ctrl_q.add_cnt ? REP_LAST_16 : REP_LAST_4;
    wire [RES_W-1:0] sum_w = acc_q + RES_W'(conv_data);
    wire [RES_W-1:0] avg_w = ctrl_q.add_cnt ? (sum_w >> SHIFT_16) : (sum_w >> SHIFT_4);
    wire slot_end = st_q == ST_CONV && slot_q == SLOT_ONE;
    wire again = slot_end && add_on && rep_q != rep_last;
    wire res_we = slot_end && !again;
    wire [RES_W-1:0] res_wd = !add_on ? RES_W'(conv_data) : // [RULE12]
                              ctrl_q.avg ? avg_w : sum_w; // [RULE13] [RULE21]
    wire to_dup = dbl_on && dbl_ph_q && !grp_b_q && conv_req_q.chan == ctrl_q.dbl_chan;
    wire [CH_W-1:0] res_wi = to_dup ? RES_DUP : conv_req_q.chan; // [RULE15]

    // sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_IDLE;
            grp_b_q <= 1'b0;
            b_pend_q <= 1'b0;
            dbl_ph_q <= 1'b0;
            rem_q <= '0;
            slot_q <= '0;
            rep_q <= '0;
            acc_q <= '0;
            conv_req_q <= '0;
            irq_a_q <= 1'b0;
            irq_b_q <= 1'b0;
        end else begin
            conv_req_q.start <= 1'b0;
            irq_a_q <= 1'b0;
            irq_b_q <= 1'b0;
            if (sw_stop) begin
                st_q <= ST_IDLE; // [RULE2]
                b_pend_q <= 1'b0;
                dbl_ph_q <= 1'b0;
            end else if (preempt) begin
                // in-flight group b result is dropped, not stored
                rem_q <= mask_a; // [RULE7]
                grp_b_q <= 1'b0;
                b_pend_q <= ctrl_q.rescan; // [RULE8]
                st_q <= ST_PICK;
            end else begin
                case (st_q)
                    ST_IDLE: begin
                        // triggers act from idle, apart from the group a preempt above [RULE23]
                        if (trig_a) begin
                            rem_q <= mask_a;
                            grp_b_q <= 1'b0;
                            st_q <= ST_PICK;
                        end else if (trig_b) begin
                            rem_q <= mask_b;
                            grp_b_q <= 1'b1;
                            st_q <= ST_PICK;
                        end
                    end
                    ST_PICK: begin
                        if (rem_q != '0) begin
                            conv_req_q.chan <= first_set(rem_q); // [RULE22]
                            conv_req_q.start <= 1'b1;
                            slot_q <= slot_len(ctrl_q.ratio); // [RULE16] [RULE17]
                            rep_q <= '0;
                            acc_q <= '0;
                            st_q <= ST_CONV;
                        end else if (ctrl_q.mode == MODE_CONT) begin
                            rem_q <= mask_a; // [RULE2]
                        end else if (grp_b_q) begin
                            irq_b_q <= 1'b1; // [RULE20]
                            grp_b_q <= 1'b0;
                            st_q <= ST_IDLE;
                        end else if (fin_a_wait) begin
                            dbl_ph_q <= 1'b1; // [RULE19]
                            st_q <= ST_IDLE;
                        end else begin
                            dbl_ph_q <= 1'b0;
                            irq_a_q <= 1'b1; // [RULE18] [RULE19] [RULE20]
                            if (b_pend_q && grp_mode) begin
                                rem_q <= mask_b; // [RULE8]
                                grp_b_q <= 1'b1;
                                b_pend_q <= 1'b0;
                            end else begin
                                st_q <= ST_IDLE; // [RULE1]
                            end
                        end
                    end
                    ST_CONV: begin
                        slot_q <= slot_q - SLOT_ONE;
                        if (again) begin
                            acc_q <= sum_w; // [RULE13]
                            rep_q <= rep_q + REP_W'(1);
                            conv_req_q.start <= 1'b1;
                            slot_q <= slot_len(ctrl_q.ratio);
                        end else if (slot_end) begin
                            rem_q[conv_req_q.chan] <= 1'b0;
                            st_q <= ST_PICK;
                        end
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end

    // result store, 16-bit words, zero above the data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NRES; i++) begin
                res_q[i] <= '0; // [RULE11]
            end
        end else if (res_we && !sw_stop && !preempt) begin
            res_q[res_wi] <= res_wd;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign conv_req = conv_req_q;
    assign scan_end_irq = irq_a_q;
    assign group_b_scan_end_irq = irq_b_q;

    // checks, on the default clock and reset
    sequence s_fin_a_rescan;
        fin_a && !fin_a_wait && b_pend_q && grp_mode && !sw_stop && !preempt;
    endsequence
    sequence s_b_started;
        grp_b_q && st_q == ST_PICK && !b_pend_q;
    endsequence
    property p_single_once;
        irq_a_q && single_mode && !b_pend_q |-> st_q == ST_IDLE;
    endproperty
    a_single_once: assert property (p_single_once) else $error("single scan did not stop"); // [RULE1]
    property p_stop;
        sw_stop |=> st_q == ST_IDLE && !conv_req_q.start;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not end scan"); // [RULE2]
    property p_preempt;
        preempt && !sw_stop |=> !grp_b_q && st_q == ST_PICK && b_pend_q == $past(ctrl_q.rescan);
    endproperty
    a_preempt: assert property (p_preempt) else $error("group a did not preempt b"); // [RULE7]
    property p_rescan;
        s_fin_a_rescan |=> s_b_started ##0 irq_a_q;
    endproperty
    a_rescan: assert property (p_rescan) else $error("group b rescan missing"); // [RULE8]
    property p_ascend;
        conv_req_q.start && !$past(again) |->
            (rem_q & ((NSLOT'(1) << conv_req_q.chan) - NSLOT'(1))) == '0 && rem_q[conv_req_q.chan];
    endproperty
    a_ascend: assert property (p_ascend) else $error("channel order not ascending"); // [RULE22]
    property p_slot;
        conv_req_q.start && ctrl_q.ratio == RATIO_1_1 |=> (!conv_req_q.start)[*8];
    endproperty
    a_slot: assert property (p_slot) else $error("conversion slot too short"); // [RULE17]
    property p_twelve;
        res_we && !add_on |-> res_wd[RES_W-1:DATA_W] == '0;
    endproperty
    a_twelve: assert property (p_twelve) else $error("normal result wider than 12 bits"); // [RULE12]
    property p_dbl_irq;
        irq_a_q && dbl_on |-> $past(dbl_ph_q);
    endproperty
    a_dbl_irq: assert property (p_dbl_irq) else $error("double scan end too early"); // [RULE19]
    property p_grp_b_irq;
        irq_b_q |-> grp_mode && !irq_a_q && $past(grp_b_q);
    endproperty
    a_grp_b_irq: assert property (p_grp_b_irq) else $error("group b end outside group b"); // [RULE20]
    property p_ignore;
        st_q == ST_CONV && (trig_a || trig_b) && !preempt && !sw_stop && !slot_end |=>
            st_q == ST_CONV;
    endproperty
    a_ignore: assert property (p_ignore) else $error("busy scan restarted by trigger"); // [RULE23]
    property p_pin;
        st_q == ST_IDLE && pin_edge && ctrl_q.trig_a == TRG_PIN && !sw_stop |=> st_q == ST_PICK;
    endproperty
    a_pin: assert property (p_pin) else $error("pin start ignored"); // [RULE10]
endmodule
`default_nettype wire

/* File: adc_scan_pkg.sv */
// constants, fields and carriers of the a/d scan sequencer
package adc_scan_pkg;
    localparam int PCLK_MHZ = 10;
    localparam int CONVERSION_CLOCK_MHZ = 32;
    localparam int CONV_TIME_NS = 1400;
    localparam int NS_PER_US = 1000;
    localparam int CONV_CONVERSION_CLOCK = (CONV_TIME_NS * CONVERSION_CLOCK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int SLOT_W = 9;
    localparam logic [SLOT_W-1:0] SLOT_ONE = 9'h001;
    localparam logic [SLOT_W-1:0] SLOT_1_1 = SLOT_W'(CONV_CONVERSION_CLOCK);
    localparam logic [SLOT_W-1:0] SLOT_1_2 = SLOT_W'((CONV_CONVERSION_CLOCK + 1) / 2);
    localparam logic [SLOT_W-1:0] SLOT_2_1 = SLOT_W'(CONV_CONVERSION_CLOCK * 2);
    localparam logic [SLOT_W-1:0] SLOT_4_1 = SLOT_W'(CONV_CONVERSION_CLOCK * 4);
    localparam logic [SLOT_W-1:0] SLOT_8_1 = SLOT_W'(CONV_CONVERSION_CLOCK * 8);
    localparam logic [2:0] RATIO_1_1 = 3'h0;
    localparam logic [2:0] RATIO_1_2 = 3'h1;
    localparam logic [2:0] RATIO_2_1 = 3'h2;
    localparam logic [2:0] RATIO_4_1 = 3'h3;
    localparam logic [2:0] RATIO_8_1 = 3'h4;
    localparam logic [2:0] TRG_SW = 3'h0;
    localparam logic [2:0] TRG_TIMER = 3'h1;
    localparam logic [2:0] TRG_ELINK = 3'h2;
    localparam logic [2:0] TRG_PIN = 3'h3;
    localparam int NCH_ANA = 24;
    localparam int NSLOT = 27;
    localparam int NRES = 28;
    localparam int CH_W = 5;
    localparam int DATA_W = 12;
    localparam int RES_W = 16;
    localparam logic [CH_W-1:0] CH_TEMP = 5'h18;
    localparam logic [CH_W-1:0] CH_VREF = 5'h19;
    localparam logic [CH_W-1:0] CH_DIAG = 5'h1A;
    localparam logic [CH_W-1:0] RES_DUP = 5'h1B;
    localparam int REP_W = 4;
    localparam logic [REP_W-1:0] REP_LAST_4 = 4'h3;
    localparam logic [REP_W-1:0] REP_LAST_16 = 4'hF;
    localparam int SHIFT_4 = 2;
    localparam int SHIFT_16 = 4;
    localparam int ADDR_W = 8;
    localparam int WORD_SHIFT = 2;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_SEL_A = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_SEL_B = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_ADDSEL = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_RES = 8'h40;
    localparam int CTRL_W = 26;
    localparam int STAT_W = 9;
    typedef enum logic [1:0] {MODE_SINGLE, MODE_CONT, MODE_GROUP, MODE_RSVD} scan_mode_t;
    typedef struct packed {
        logic [2:0] ratio;
        logic [CH_W-1:0] dbl_chan;
        logic [2:0] trig_b;
        logic [2:0] trig_a;
        logic diag_en;
        logic vref_en;
        logic temp_en;
        logic add_cnt;
        logic avg;
        logic rescan;
        logic prio;
        logic dbl_en;
        scan_mode_t mode;
        logic stop;
        logic start;
    } ctrl_t;
    typedef struct packed {
        logic dbl_ph;
        logic b_pend;
        logic grp_b;
        logic busy;
        logic [CH_W-1:0] chan;
    } status_t;
    typedef struct packed {
        logic start;
        logic [CH_W-1:0] chan;
    } conv_req_t;
endpackage

/* File: conv_core_model.sv */
// behavioural converter core answering each conversion slot
`timescale 1ns/100ps
`default_nettype none
module conv_core_model #(
    parameter int SETTLE = 2
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // sequencer side
    input wire adc_scan_pkg::conv_req_t conv_req,
    input wire logic [11:0] bias,
    output logic [11:0] conv_data
);
    import adc_scan_pkg::*;
    logic [11:0] val_q;
    logic [8:0] age_q;
    // unsettled data toggles so an early sample is caught
    assign conv_data = (age_q >= SETTLE) ? val_q : ~val_q ^ {3{age_q[3:0]}};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            val_q <= 12'hA5C;
            age_q <= 9'h000;
        end else if (conv_req.start) begin
            val_q <= {conv_req.chan, 7'h2B} ^ bias;
            age_q <= 9'h000;
        end else if (age_q != 9'h1FF) begin
            age_q <= age_q + 9'h001;
        end
    end
endmodule
`default_nettype wire

/* File: adc_scan_sequencer_test.sv */
// self-checking bench for the scan sequencer
`timescale 1ns/100ps
`default_nettype none
module adc_scan_sequencer_test;
    import adc_scan_pkg::*;
    typedef struct {logic [2:0] src; logic [2:0] ratio; int lo; int hi; int gap;} row_t;
    row_t rows[5] = '{'{TRG_SW, RATIO_1_1, 0, 23, 46}, '{TRG_TIMER, RATIO_1_2, 5, 6, 24},
        '{TRG_ELINK, RATIO_2_1, 1, 9, 91}, '{TRG_PIN, RATIO_4_1, 2, 3, 181},
        '{TRG_SW, RATIO_8_1, 4, 22, 361}};
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, e1;
    logic pready, pslverr, serr, tmr = 1'b0, elk = 1'b0, pin_n = 1'b1;
    logic [11:0] conv_data, bias = 12'h000;
    logic scan_end_irq, group_b_scan_end_irq;
    conv_req_t conv_req;
    ctrl_t cfg;
    int err_total = 0, compares = 0, cyc = 0, last = 0, na = 0, nb = 0, n0;
    logic [CH_W-1:0] seen[$];
    int gaps[$];
    always #50 pclk = ~pclk;
    adc_scan_sequencer adc_scan_sequencer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_pulse_unit_trig(tmr),
        .event_link_unit_trig(elk), .external_start_pin_n(pin_n), .conv_req(conv_req),
        .conv_data(conv_data), .scan_end_irq(scan_end_irq),
        .group_b_scan_end_irq(group_b_scan_end_irq));
    conv_core_model #(.SETTLE(20)) conv_core_model_i (.pclk(pclk), .presetn(presetn),
        .conv_req(conv_req), .bias(bias), .conv_data(conv_data));
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (conv_req.start === 1'b1) begin
            seen.push_back(conv_req.chan);
            gaps.push_back(cyc - last);
            last <= cyc;
        end
        if (scan_end_irq === 1'b1) na <= na + 1;
        if (group_b_scan_end_irq === 1'b1) nb <= nb + 1;
        if (cyc == 60000) begin
            err_total++;
            final_report();
        end
    end
    task automatic final_report();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic fire(input logic [2:0] src);
        seen.delete();
        gaps.delete();
        case (src)
            TRG_SW: begin
                // start acts on the stored setup, so store it first
                apb(1'b1, OFF_CTRL, 32'(cfg));
                apb(1'b1, OFF_CTRL, 32'(cfg) | 32'h1);
            end
            TRG_TIMER: tmr <= 1'b1;
            TRG_ELINK: elk <= 1'b1;
            default: pin_n <= 1'b0;
        endcase
        // on-chip triggers pulse one cycle, the pin outlasts its synchroniser
        @(posedge pclk);
        tmr <= 1'b0;
        elk <= 1'b0;
        repeat (3) @(posedge pclk);
        pin_n <= 1'b1;
    endtask
    task automatic wait_irq(input int a, input int b);
        for (int k = 0; k < 9000 && (na < a || nb < b); k++) @(posedge pclk);
        repeat (3) @(posedge pclk);
    endtask
    function automatic logic [31:0] expv(input int ch);
        return {20'h0, 5'(ch), 7'h2B} ^ {20'h0, bias};
    endfunction
    initial begin
        repeat (4) @(posedge pclk);
        check({conv_req, scan_end_irq, pready}, 0);
        presetn <= 1'b1;
        apb(1'b0, OFF_RES + 8'h14, 0);
        check(rd, 0);
        apb(1'b1, 8'h20, 32'h5);
        check(rd, 0);
        check(serr, 1);
        $display("reset and register bus done");
        foreach (rows[i]) begin
            cfg = '0;
            cfg.trig_a = rows[i].src;
            cfg.ratio = rows[i].ratio;
            bias <= 12'(i * 273);
            apb(1'b1, OFF_SEL_A, (32'h1 << rows[i].lo) | (32'h1 << rows[i].hi));
            apb(1'b1, OFF_CTRL, 32'(cfg));
            n0 = na;
            fire(rows[i].src);
            wait_irq(n0 + 1, 0);
            check(seen.size(), 2);
            check({seen[0], seen[1]}, {5'(rows[i].lo), 5'(rows[i].hi)});
            check(gaps[1], rows[i].gap);
            check(na, n0 + 1);
            apb(1'b0, OFF_RES + 8'(4 * rows[i].hi), 0);
            check(rd, expv(rows[i].hi));
            $display("row %0d done", i);
        end
        cfg = '0;
        cfg.temp_en = 1'b1;
        cfg.vref_en = 1'b1;
        apb(1'b1, OFF_SEL_A, 32'h80);
        fire(TRG_SW);
        wait_irq(na + 1, 0);
        check({seen[0], seen[1], seen[2]}, {5'd7, CH_TEMP, CH_VREF});
        apb(1'b0, OFF_RES + 8'h60, 0);
        check(rd, expv(24));
        $display("extended inputs done");
        cfg.mode = MODE_CONT;
        apb(1'b1, OFF_SEL_A, 32'h180);
        fire(TRG_SW);
        repeat (300) @(posedge pclk);
        check(seen.size() >= 5 && seen[2] == 7, 1);
        apb(1'b1, OFF_CTRL, 32'(cfg) | 32'h2);
        @(posedge pclk);
        n0 = seen.size();
        repeat (100) @(posedge pclk);
        check(seen.size(), n0);
        $display("continuous done");
        cfg = '0;
        cfg.mode = MODE_GROUP;
        cfg.prio = 1'b1;
        cfg.rescan = 1'b1;
        cfg.trig_a = TRG_TIMER;
        cfg.trig_b = TRG_ELINK;
        apb(1'b1, OFF_CTRL, 32'(cfg));
        apb(1'b1, OFF_SEL_A, 32'h10);
        apb(1'b1, OFF_SEL_B, 32'h600);
        n0 = na;
        fire(TRG_ELINK);
        elk <= 1'b1;
        @(posedge pclk);
        elk <= 1'b0;
        tmr <= 1'b1;
        @(posedge pclk);
        tmr <= 1'b0;
        wait_irq(n0 + 1, nb + 1);
        check(seen.size(), 4);
        check({seen[0], seen[1], seen[2], seen[3]}, {5'd9, 5'd4, 5'd9, 5'd10});
        check(na - n0, 1);
        check(nb, 1);
        $display("group done");
        cfg = '0;
        cfg.dbl_en = 1'b1;
        cfg.dbl_chan = 5'h06;
        apb(1'b1, OFF_SEL_A, 32'h40);
        n0 = na;
        fire(TRG_SW);
        repeat (60) @(posedge pclk);
        check(na, n0);
        e1 = expv(6);
        bias <= 12'h00F;
        fire(TRG_SW);
        wait_irq(n0 + 1, 0);
        apb(1'b0, OFF_RES + 8'h18, 0);
        check(rd, e1);
        apb(1'b0, OFF_RES + 8'h6C, 0);
        check(rd, expv(6));
        $display("double trigger done");
        // add four, average four, add sixteen
        apb(1'b1, OFF_SEL_A, 32'h8);
        apb(1'b1, OFF_ADDSEL, 32'h8);
        for (int m = 0; m < 3; m++) begin
            cfg = '0;
            cfg.avg = (m == 1);
            cfg.add_cnt = (m == 2);
            fire(TRG_SW);
            wait_irq(na + 1, 0);
            apb(1'b0, OFF_RES + 8'h0C, 0);
            check(rd, expv(3) << (m == 0 ? 2 : m == 1 ? 0 : 4));
        end
        $display("addition done");
        final_report();
    end
endmodule
`default_nettype wire
